/* verilog/srm_pkg.sv */
// Constants for the secondary serial port receive slot map, channels 4 to 6
// Functional notes
// - Channel 4 enable bit 5 routes to DAC4
// - Five-bit slot field; TDM value selects slot n
// - I2S/left-justified: 0-15 left, 16-31 right slots
// - Channel 5 source: off, DAC5, ADC1 loopback, reserved
// - Channel 6 source: off, DAC6, ADC2 loopback, linked device
// - Reset values 0x03, 0x04, 0x05; channels disabled
`default_nettype none
package srm_pkg;
  // AXI4-Lite
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_CH4 = 6'h2b;
  localparam logic [5:0] IDX_CH5 = 6'h2c;
  localparam logic [5:0] IDX_CH6 = 6'h2d;
  localparam logic [5:0] IDX_CTRL = 6'h30;
  localparam logic [5:0] IDX_STAT = 6'h31;
  // Reset values and writable masks
  localparam logic [7:0] RST_CH4 = 8'h03;
  localparam logic [7:0] RST_CH5 = 8'h04;
  localparam logic [7:0] RST_CH6 = 8'h05;
  localparam logic [7:0] MASK_CH4 = 8'h3f;
  localparam logic [7:0] MASK_CH56 = 8'h7f;
  localparam logic [1:0] RST_FMT = 2'h0;
  // Field positions
  localparam int EN_BIT = 5;
  localparam int SRC_HI = 6;
  localparam int SRC_LO = 5;
  localparam int SLOT_HI = 4;
  localparam int SLOT_LO = 0;
  localparam int FMT_HI = 1;
  localparam int STAT_OVF_BIT = 0;
  localparam int STAT_LVL_LSB = 8;
  // Source selector codes
  localparam logic [1:0] SRC_OFF = 2'h0;
  localparam logic [1:0] SRC_DAC = 2'h1;
  localparam logic [1:0] SRC_LOOP = 2'h2;
  localparam logic [1:0] SRC_LINK = 2'h3;
  // Destination codes on the output stream
  localparam logic [1:0] DEST_DAC = 2'h0;
  localparam logic [1:0] DEST_LOOP = 2'h1;
  localparam logic [1:0] DEST_LINK = 2'h2;
  // Frame formats
  localparam logic [1:0] FMT_TDM = 2'h0;
  localparam logic [1:0] FMT_I2S = 2'h1;
  localparam logic [1:0] FMT_LJ = 2'h2;
  // Serial framing: 32-bit slots, 32 slots per frame
  localparam int CNT_W = 10;
  localparam logic [4:0] WORD_END = 5'h1f;
  localparam int NCH = 3;
  localparam logic [1:0] CH4_ID = 2'h0;
  localparam logic [1:0] CH5_ID = 2'h1;
  localparam logic [1:0] CH6_ID = 2'h2;
  // Sample buffer
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_AW = 4;
  localparam int FIFO_W = 36;
endpackage : srm_pkg
`default_nettype wire

/* verilog/srm_sync.sv */
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
`default_nettype none
module srm_sync (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Pin and filtered level
  input wire logic d,
  output logic q
);
  logic s1, s2, s3;
  logic next_q;

  // Only the second and third stages are compared; the first is metastable-prone
  always_comb begin
    next_q = q;
    if (s2 == s3) begin
      next_q = s3;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      q <= 1'b0;
    end else begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
      q <= next_q;
    end
  end
endmodule : srm_sync
`default_nettype wire

/* verilog/srm_fifo.sv */
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ns
`default_nettype none
module srm_fifo #(
  parameter int W = 36,
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data,
  // Fill level
  output logic [AW:0] level
);
  logic [W-1:0] mem [DEPTH];
  logic [AW:0] wptr, rptr;
  logic [AW:0] next_wptr, next_rptr;
  logic push, pop;

  assign level = wptr - rptr;
  assign in_ready = (level != AW'(0) + (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
  assign out_valid = (wptr != rptr);
  assign out_data = mem[rptr[AW-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    next_wptr = wptr;
    next_rptr = rptr;
    if (push) begin
      next_wptr = wptr + (AW+1)'(1);
    end
    if (pop) begin
      next_rptr = rptr + (AW+1)'(1);
    end
  end

  // Storage has no reset; only pointers need a defined value
  always_ff @(posedge aclk) begin
    if (push) begin
      mem[wptr[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wptr <= '0;
      rptr <= '0;
    end else begin
      wptr <= next_wptr;
      rptr <= next_rptr;
    end
  end
endmodule : srm_fifo
`default_nettype wire

/* verilog/srm_rx_map.sv */
// Secondary serial port receive slot map for channels 4 to 6, AXI4-Lite slave
`timescale 1ns/1ns
`default_nettype none
module srm_rx_map (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Serial audio pins
  input wire logic bclk,
  input wire logic fsync,
  input wire logic sdin,
  // Routed sample stream
  output logic smp_valid,
  input wire logic smp_ready,
  output logic [31:0] smp_data,
  output logic [1:0] smp_chan,
  output logic [1:0] smp_dest
);
  // Register state
  logic [7:0] map4, map5, map6;
  logic [1:0] fmt;
  logic ovf;
  logic [7:0] next_map4, next_map5, next_map6;
  logic [1:0] next_fmt;
  logic next_ovf;

  // Bus state
  logic aw_held, w_held;
  logic [5:0] aw_idx;
  logic [31:0] w_data;
  logic w_lane0;
  logic [1:0] bresp;
  logic bvalid;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic next_aw_held, next_w_held;
  logic [5:0] next_aw_idx;
  logic [31:0] next_w_data;
  logic next_w_lane0;
  logic [1:0] next_bresp;
  logic next_bvalid;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;
  logic next_rvalid;

  // Receiver state
  logic bclk_q, fs_q, sd_q;
  logic bclk_d;
  logic fs_prev, eff_prev;
  logic [srm_pkg::CNT_W-1:0] cnt;
  logic [31:0] shreg;
  logic [srm_pkg::NCH-1:0] pend;
  logic [31:0] word;
  logic next_bclk_d;
  logic next_fs_prev, next_eff_prev;
  logic [srm_pkg::CNT_W-1:0] next_cnt;
  logic [31:0] next_shreg;
  logic [srm_pkg::NCH-1:0] next_pend;
  logic [31:0] next_word;

  // Derived channel view
  logic [4:0] slot [srm_pkg::NCH];
  logic [srm_pkg::NCH-1:0] chan_en;
  logic [1:0] chan_dest [srm_pkg::NCH];
  logic [1:0] src5, src6;

  // Datapath glue
  logic bclk_rise;
  logic eff_fs;
  logic [4:0] slot_code;
  logic slot_ok;
  logic word_done;
  logic [srm_pkg::NCH-1:0] hit;
  logic [1:0] sel;
  logic [srm_pkg::NCH-1:0] sel_mask;
  logic fifo_in_ready;
  logic [srm_pkg::FIFO_W-1:0] fifo_out;
  logic [srm_pkg::FIFO_AW:0] fifo_level;
  logic wr_go;

  srm_sync u_sync_bclk (.aclk(aclk), .aresetn(aresetn), .d(bclk), .q(bclk_q));
  srm_sync u_sync_fs (.aclk(aclk), .aresetn(aresetn), .d(fsync), .q(fs_q));
  srm_sync u_sync_sd (.aclk(aclk), .aresetn(aresetn), .d(sdin), .q(sd_q));

  // Channel enables and destinations
  assign src5 = map5[srm_pkg::SRC_HI:srm_pkg::SRC_LO];
  assign src6 = map6[srm_pkg::SRC_HI:srm_pkg::SRC_LO];
  assign slot[0] = map4[srm_pkg::SLOT_HI:srm_pkg::SLOT_LO];
  assign slot[1] = map5[srm_pkg::SLOT_HI:srm_pkg::SLOT_LO];
  assign slot[2] = map6[srm_pkg::SLOT_HI:srm_pkg::SLOT_LO];
  assign chan_en[0] = map4[srm_pkg::EN_BIT];
  // Reserved code 3 on channel 5 is treated as off
  assign chan_en[1] = (src5 == srm_pkg::SRC_DAC) || (src5 == srm_pkg::SRC_LOOP);
  assign chan_en[2] = (src6 != srm_pkg::SRC_OFF);

  always_comb begin
    chan_dest[0] = srm_pkg::DEST_DAC;
    chan_dest[1] = srm_pkg::DEST_DAC;
    if (src5 == srm_pkg::SRC_LOOP) begin
      chan_dest[1] = srm_pkg::DEST_LOOP;
    end
    unique case (src6)
      srm_pkg::SRC_LOOP: chan_dest[2] = srm_pkg::DEST_LOOP;
      srm_pkg::SRC_LINK: chan_dest[2] = srm_pkg::DEST_LINK;
      default: chan_dest[2] = srm_pkg::DEST_DAC;
    endcase
  end

  // Frame decode; I2S is read as left-justified with frame sync inverted and one bit late
  assign bclk_rise = bclk_q && !bclk_d;
  assign eff_fs = (fmt == srm_pkg::FMT_I2S) ? !fs_prev : fs_q;

  always_comb begin
    next_bclk_d = bclk_q;
    next_fs_prev = fs_prev;
    next_eff_prev = eff_prev;
    next_cnt = cnt;
    next_shreg = shreg;
    if (bclk_rise) begin
      next_fs_prev = fs_q;
      next_eff_prev = eff_fs;
      next_shreg = {shreg[30:0], sd_q};
      next_cnt = cnt + srm_pkg::CNT_W'(1);
      if (fmt == srm_pkg::FMT_I2S || fmt == srm_pkg::FMT_LJ) begin
        if (eff_fs != eff_prev) begin
          next_cnt = '0;
        end
      end else if (fs_q && !fs_prev) begin
        next_cnt = '0;
      end
    end
  end

  // TDM uses the slot index directly; I2S/LJ put the right half at 16-31
  always_comb begin
    if (fmt == srm_pkg::FMT_I2S || fmt == srm_pkg::FMT_LJ) begin
      slot_code = {!eff_fs, next_cnt[8:5]};
      slot_ok = !next_cnt[9];
    end else begin
      slot_code = next_cnt[9:5];
      slot_ok = 1'b1;
    end
  end

  assign word_done = bclk_rise && (next_cnt[4:0] == srm_pkg::WORD_END) && slot_ok;

  always_comb begin
    for (int i = 0; i < srm_pkg::NCH; i++) begin
      hit[i] = chan_en[i] && (slot[i] == slot_code);
    end
  end

  // One push per cycle, lowest channel first; a word completes every 32 bit clocks
  always_comb begin
    sel = srm_pkg::CH6_ID;
    if (pend[0]) begin
      sel = srm_pkg::CH4_ID;
    end else if (pend[1]) begin
      sel = srm_pkg::CH5_ID;
    end
  end

  assign sel_mask = srm_pkg::NCH'(1) << sel;

  always_comb begin
    next_pend = pend;
    next_word = word;
    if ((pend != '0) && fifo_in_ready) begin
      next_pend = pend & ~sel_mask;
    end
    if (word_done && (hit != '0) && (next_pend == '0)) begin
      next_pend = hit;
      next_word = next_shreg;
    end
  end

  srm_fifo #(
    .W(srm_pkg::FIFO_W),
    .DEPTH(srm_pkg::FIFO_DEPTH),
    .AW(srm_pkg::FIFO_AW)
  ) u_fifo (
    .aclk(aclk),
    .aresetn(aresetn),
    .in_valid(pend != '0),
    .in_ready(fifo_in_ready),
    .in_data({sel, chan_dest[sel], word}),
    .out_valid(smp_valid),
    .out_ready(smp_ready),
    .out_data(fifo_out),
    .level(fifo_level)
  );

  assign smp_data = fifo_out[31:0];
  assign smp_dest = fifo_out[33:32];
  assign smp_chan = fifo_out[35:34];

  // AXI4-Lite: address and data taken in either order, response after both
  assign s_axi_awready = !aw_held && !bvalid;
  assign s_axi_wready = !w_held && !bvalid;
  assign s_axi_arready = !rvalid;
  assign s_axi_bvalid = bvalid;
  assign s_axi_bresp = bresp;
  assign s_axi_rvalid = rvalid;
  assign s_axi_rresp = rresp;
  assign s_axi_rdata = rdata;
  assign wr_go = (aw_held || (s_axi_awvalid && s_axi_awready))
      && (w_held || (s_axi_wvalid && s_axi_wready)) && !bvalid;

  always_comb begin
    next_aw_held = aw_held;
    next_aw_idx = aw_idx;
    next_w_held = w_held;
    next_w_data = w_data;
    next_w_lane0 = w_lane0;
    next_bvalid = bvalid;
    next_bresp = bresp;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_aw_idx = s_axi_awaddr[7:2];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_lane0 = s_axi_wstrb[0];
    end
    if (bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (wr_go) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      unique case (next_aw_idx)
        srm_pkg::IDX_CH4, srm_pkg::IDX_CH5, srm_pkg::IDX_CH6,
        srm_pkg::IDX_CTRL, srm_pkg::IDX_STAT: next_bresp = srm_pkg::RESP_OK;
        default: next_bresp = srm_pkg::RESP_SLVERR;
      endcase
    end
  end

  // Register writes; reserved bits are masked so they always read zero
  always_comb begin
    next_map4 = map4;
    next_map5 = map5;
    next_map6 = map6;
    next_fmt = fmt;
    next_ovf = ovf;
    if (wr_go && next_w_lane0) begin
      unique case (next_aw_idx)
        srm_pkg::IDX_CH4: next_map4 = next_w_data[7:0] & srm_pkg::MASK_CH4;
        srm_pkg::IDX_CH5: next_map5 = next_w_data[7:0] & srm_pkg::MASK_CH56;
        srm_pkg::IDX_CH6: next_map6 = next_w_data[7:0] & srm_pkg::MASK_CH56;
        srm_pkg::IDX_CTRL: next_fmt = next_w_data[srm_pkg::FMT_HI:0];
        srm_pkg::IDX_STAT: begin
          if (next_w_data[srm_pkg::STAT_OVF_BIT]) begin
            next_ovf = 1'b0;
          end
        end
        default: next_fmt = fmt;
      endcase
    end
    // A word lost to a busy push stage sets overflow; set wins over clear
    if (word_done && (hit != '0) && (pend != '0)) begin
      if (!(((pend & ~sel_mask) == '0) && fifo_in_ready)) begin
        next_ovf = 1'b1;
      end
    end
  end

  always_comb begin
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    if (rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp = srm_pkg::RESP_OK;
      next_rdata = '0;
      unique case (s_axi_araddr[7:2])
        srm_pkg::IDX_CH4: next_rdata[7:0] = map4;
        srm_pkg::IDX_CH5: next_rdata[7:0] = map5;
        srm_pkg::IDX_CH6: next_rdata[7:0] = map6;
        srm_pkg::IDX_CTRL: next_rdata[srm_pkg::FMT_HI:0] = fmt;
        srm_pkg::IDX_STAT: begin
          next_rdata[srm_pkg::STAT_OVF_BIT] = ovf;
          next_rdata[srm_pkg::STAT_LVL_LSB +: srm_pkg::FIFO_AW+1] = fifo_level;
        end
        default: next_rresp = srm_pkg::RESP_SLVERR;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      map4 <= srm_pkg::RST_CH4;
      map5 <= srm_pkg::RST_CH5;
      map6 <= srm_pkg::RST_CH6;
      fmt <= srm_pkg::RST_FMT;
      ovf <= 1'b0;
    end else begin
      map4 <= next_map4;
      map5 <= next_map5;
      map6 <= next_map6;
      fmt <= next_fmt;
      ovf <= next_ovf;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_idx <= '0;
      w_held <= 1'b0;
      w_data <= '0;
      w_lane0 <= 1'b0;
      bvalid <= 1'b0;
      bresp <= srm_pkg::RESP_OK;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= srm_pkg::RESP_OK;
    end else begin
      aw_held <= next_aw_held;
      aw_idx <= next_aw_idx;
      w_held <= next_w_held;
      w_data <= next_w_data;
      w_lane0 <= next_w_lane0;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bclk_d <= 1'b0;
      fs_prev <= 1'b0;
      eff_prev <= 1'b0;
      cnt <= '0;
      shreg <= '0;
      pend <= '0;
      word <= '0;
    end else begin
      bclk_d <= next_bclk_d;
      fs_prev <= next_fs_prev;
      eff_prev <= next_eff_prev;
      cnt <= next_cnt;
      shreg <= next_shreg;
      pend <= next_pend;
      word <= next_word;
    end
  end
endmodule : srm_rx_map
`default_nettype wire

/* verilog/srm_fifo_note_unused.sv */
// Spare source file; holds no logic
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

/* verif/srm_rx_map_monitor.sv */
// Concurrent checks on the receive slot map ports
`timescale 1ns/1ns
`default_nettype none
module srm_rx_map_monitor (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  // Sample stream
  input wire logic smp_valid,
  input wire logic smp_ready,
  input wire logic [31:0] smp_data,
  input wire logic [1:0] smp_chan,
  input wire logic [1:0] smp_dest
);
  logic [7:0] wa, next_wa, ra, next_ra, shr;
  logic [8:0] wd, next_wd;
  logic [7:0] sh [3];
  logic [7:0] next_sh [3];
  logic [2:0] seen, next_seen;
  logic hit;
  // Shadow follows completed writes only, so reads must not overlap writes
  always_comb begin
    next_wa = wa;
    next_wd = wd;
    next_ra = ra;
    next_sh = sh;
    hit = 1'b0;
    shr = 8'h00;
    if (s_axi_awvalid && s_axi_awready) next_wa = s_axi_awaddr;
    if (s_axi_wvalid && s_axi_wready) next_wd = {s_axi_wstrb[0], s_axi_wdata[7:0]};
    if (s_axi_arvalid && s_axi_arready) next_ra = s_axi_araddr;
    for (int i = 0; i < 3; i++) begin
      if (s_axi_bvalid && s_axi_bready && wd[8] && wa[7:2] == srm_pkg::IDX_CH4 + 6'(i))
        next_sh[i] = wd[7:0] & (i == 0 ? srm_pkg::MASK_CH4 : srm_pkg::MASK_CH56);
      if (ra[7:2] == srm_pkg::IDX_CH4 + 6'(i)) begin
        hit = 1'b1;
        shr = sh[i];
      end
    end
    next_seen = seen | {sh[2][6:5] == srm_pkg::SRC_LINK, sh[1][6:5] == srm_pkg::SRC_LOOP,
      sh[0][srm_pkg::EN_BIT]};
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wa <= 8'h00;
      wd <= 9'h000;
      ra <= 8'h00;
      sh <= '{srm_pkg::RST_CH4, srm_pkg::RST_CH5, srm_pkg::RST_CH6};
      seen <= 3'h0;
    end else begin
      wa <= next_wa;
      wd <= next_wd;
      ra <= next_ra;
      sh <= next_sh;
      seen <= next_seen;
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  shadow_read_a : assert property (
    s_axi_rvalid && hit |-> s_axi_rdata == {24'h00_0000, shr})
    else $error("map register readback differs");
  reserved_zero_a : assert property (
    s_axi_rvalid && hit |-> s_axi_rresp == srm_pkg::RESP_OK && s_axi_rdata[31:7] == 25'h0)
    else $error("map register upper bits not zero");
  read_answer_a : assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  ch4_dest_a : assert property (
    smp_valid && smp_chan == srm_pkg::CH4_ID |-> smp_dest == srm_pkg::DEST_DAC)
    else $error("channel 4 sample not sent to converter");
  ch5_dest_a : assert property (
    smp_valid && smp_chan == srm_pkg::CH5_ID |->
      smp_dest != srm_pkg::DEST_LINK && (smp_dest != srm_pkg::DEST_LOOP || seen[1]))
    else $error("channel 5 destination wrong");
  ch6_link_a : assert property (
    smp_valid && smp_chan == srm_pkg::CH6_ID && smp_dest == srm_pkg::DEST_LINK |-> seen[2])
    else $error("channel 6 linked data never selected");
  ch4_off_a : assert property (
    smp_valid && smp_chan == srm_pkg::CH4_ID |-> seen[0])
    else $error("disabled channel 4 forwarded");
  smp_hold_a : assert property (
    smp_valid && !smp_ready |=> smp_valid && $stable(smp_data) && $stable({smp_chan, smp_dest}))
    else $error("stalled sample changed");
endmodule : srm_rx_map_monitor
bind srm_rx_map srm_rx_map_monitor mon_u (.*);
`default_nettype wire

/* verif/srm_host_model.sv */
// Serial audio source standing in for the host processor
`timescale 1ns/1ns
`default_nettype none
module srm_host_model (
  // Serial audio pins
  output logic bclk,
  output logic fsync,
  output logic sdin
);
  logic [31:0] slot_q [$];
  initial begin
    bclk = 1'b0;
    fsync = 1'b0;
    sdin = 1'b0;
  end
  // Format 0 tdm, 1 i2s, 2 left-justified; nl slots in the left half
  task automatic send(input logic [1:0] fmt, input int nl);
    int n;
    n = 32 * slot_q.size();
    fsync = (fmt == 2'h1);
    #37;
    // I2S data trails its frame edge by one clock: one rise high, one low
    if (fmt == 2'h1) begin
      for (int p = 0; p < 2; p++) begin
        fsync = (p == 0);
        sdin = ~sdin;
        #40 bclk = 1'b1;
        #40 bclk = 1'b0;
      end
    end
    for (int i = 0; i < n; i++) begin
      if (fmt == 2'h0) fsync = (i == 0);
      else if (fmt == 2'h1) fsync = (i + 1) / 32 >= nl;
      else fsync = i / 32 < nl;
      sdin = slot_q[i / 32][31 - i % 32];
      #40 bclk = 1'b1;
      #40 bclk = 1'b0;
    end
    // Clock stops between frames; data line shows no stale bit
    sdin = ~sdin;
    slot_q.delete();
  endtask : send
endmodule : srm_host_model
`default_nettype wire

/* verif/tb_top.sv */
// Self-checking bench for the receive slot map
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, smp_valid, smp_ready, bclk, fsync, sdin, hold;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, smp_data;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, smp_chan, smp_dest;
  logic [7:0] rf [3];
  logic [35:0] exq [$];
  int err_total, tests_run;
  integer seed = 32'h0000_62e1;
  srm_rx_map dut_u (.*);
  srm_host_model host_u (.bclk(bclk), .fsync(fsync), .sdin(sdin));
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  task automatic bad(input string m);
    err_total++;
    $display("BAD %0t %s", $time, m);
  endtask : bad
  function automatic logic [1:0] resp(input logic [7:0] a);
    return (a inside {8'hac, 8'hb0, 8'hb4, 8'hc0, 8'hc4}) ? 2'h0 : 2'h2;
  endfunction : resp
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h00_0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    tests_run++;
    if (s_axi_bresp !== resp(a)) bad("write response");
    for (int c = 0; c < 3; c++)
      if (a == 8'hac + 8'(4 * c)) rf[c] = d & (c == 0 ? 8'h3f : 8'h7f);
    @(posedge aclk);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    tests_run++;
    if (s_axi_rdata !== e || s_axi_rresp !== resp(a)) bad("read data");
    @(posedge aclk);
  endtask : rd
  // Reference routing: slot key per format, then each channel in order 4, 5, 6
  task automatic frame(input logic [1:0] fmt, input int nl, input int ns);
    logic [31:0] w;
    logic [1:0] src;
    int key;
    for (int j = 0; j < ns; j++) begin
      w = $random(seed);
      host_u.slot_q.push_back(w);
      if (fmt == 2'h0) key = j;
      else if (j < nl) key = j < 16 ? j : 99;
      else key = j - nl < 16 ? 16 + j - nl : 99;
      for (int c = 0; c < 3; c++) begin
        src = c == 0 ? {1'b0, rf[0][5]} : rf[c][6:5];
        if (rf[c][4:0] == key && (src == 1 || src == 2 || (c == 2 && src == 3)))
          exq.push_back({2'(c), src - 2'h1, w});
      end
    end
    host_u.send(fmt, nl);
    @(posedge aclk);
  endtask : frame
  task automatic done(input string nm);
    int n;
    n = 0;
    repeat (8) @(posedge aclk);
    while ((exq.size() != 0 || smp_valid !== 1'b0) && n < 4000) begin
      @(posedge aclk);
      n++;
    end
    if (n >= 4000) bad("stream stalled");
    $display("test %s done", nm);
  endtask : done
  always @(posedge aclk) begin
    if (aresetn && smp_valid && smp_ready) begin
      tests_run++;
      if (exq.size() == 0) bad("unexpected sample");
      else if ({smp_chan, smp_dest, smp_data} !== exq.pop_front()) bad("sample");
    end
    smp_ready <= !hold && ($random(seed) & 1);
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict
  initial begin
    #400_000;
    bad("timeout");
    give_verdict();
  end
  initial begin
    aresetn = 1'b0;
    hold = 1'b0;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'hf;
    rf = '{8'h03, 8'h04, 8'h05};
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int c = 0; c < 3; c++) rd(8'hac + 8'(4 * c), {24'h00_0000, rf[c]});
    rd(8'hb8, 32'h0000_0000);
    wr(8'hb8, 8'hff);
    for (int c = 0; c < 3; c++) begin
      // Reserved bits are written only at their reset value
      wr(8'hac + 8'(4 * c), c == 0 ? 8'h3f : 8'h7f);
      rd(8'hac + 8'(4 * c), {24'h00_0000, rf[c]});
    end
    done("registers");
    wr(8'hac, 8'h20);
    wr(8'hb0, 8'h3f);
    wr(8'hb4, 8'h60);
    frame(2'h0, 32, 32);
    done("full tdm frame");
    // Channel 4 disabled on slot 0 while the selectors walk every code
    wr(8'hac, 8'h00);
    for (int k = 0; k < 4; k++) begin
      wr(8'hb0, {1'b0, 2'(k), 5'h01});
      wr(8'hb4, {1'b0, 2'(k), 5'h02});
      frame(2'h0, 3, 3);
    end
    done("selector codes");
    wr(8'hac, 8'h30);
    wr(8'hb0, 8'h20);
    wr(8'hb4, 8'h51);
    for (int f = 1; f < 3; f++) begin
      wr(8'hc0, 8'(f));
      frame(2'(f), 1, 3);
    end
    done("half formats");
    wr(8'hc0, 8'h00);
    hold <= 1'b1;
    wr(8'hac, 8'h20);
    wr(8'hb0, 8'h20);
    wr(8'hb4, 8'h00);
    repeat (8) frame(2'h0, 1, 1);
    repeat (10) @(posedge aclk);
    rd(8'hc4, 32'h0000_1000);
    hold <= 1'b0;
    done("buffer fill");
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
